/* File: src/msf_pkg.sv */
package msf_pkg;

  //////////////////////////////////////////////////////////////////////////
  // timing
  localparam int unsigned CLK_PERIOD_NS = 50;
  localparam int unsigned CODE_WINDOW_NS = 11000;
  // exact division, no rounding needed
  localparam int unsigned CODE_WINDOW_CYC = CODE_WINDOW_NS / CLK_PERIOD_NS;
  localparam logic [7:0] CODE_WIN_LAST = 8'(CODE_WINDOW_CYC - 1);

  //////////////////////////////////////////////////////////////////////////
  // register map: printed offsets are word indices, byte address = 4*index
  localparam int ADDR_W = 12;
  localparam logic [9:0] IDX_STATUS_ONE = 10'h041;
  localparam logic [9:0] IDX_STATUS_TWO = 10'h042;
  localparam logic [9:0] IDX_PIN_CFG = 10'h060;
  localparam logic [9:0] IDX_LIVE_CAUSE = 10'h061;

  // reset values
  localparam logic [7:0] STATUS_RST = 8'h00;
  localparam logic [31:0] RDATA_RST = 32'h0000_0000;

  // status one fields
  localparam int ST1_V25 = 0;
  localparam int ST1_VCORE = 1;
  localparam int ST1_VSUP = 2;
  localparam int ST1_V5_TIMER = 3;
  localparam int ST1_REMOTE_ONE = 4;
  localparam int ST1_LOCAL = 5;
  localparam int ST1_REMOTE_TWO = 6;
  localparam int ST1_ANY_TWO = 7;

  // status two fields
  localparam int ST2_V12_CODE = 0;
  localparam int ST2_OVERHEAT = 1;
  localparam int ST2_FAN_ONE = 2;
  localparam int ST2_FAN_FOUR = 5;
  localparam int ST2_DIODE_ONE = 6;

  // pin configuration register fields
  localparam int CFG_PIN20 = 0;
  localparam int CFG_PIN21 = 1;
  localparam int CFG_PIN14_LO = 2;

  //////////////////////////////////////////////////////////////////////////
  // types
  typedef enum logic [1:0] {
    MSF_P14_TACH = 2'b00,
    MSF_P14_GPIO = 2'b01,
    MSF_P14_TIMER = 2'b10
  } msf_pin14_e;

  typedef struct packed {
    msf_pin14_e pin14_mode;
    logic pin21_code;
    logic pin20_overheat;
  } msf_cfg_s;

  // readings and limits from same-clock measurement logic
  typedef struct packed {
    logic [4:0][7:0] volt;
    logic [4:0][7:0] volt_hi;
    logic [4:0][7:0] volt_lo;
    logic [2:0][7:0] temp;
    logic [2:0][7:0] temp_hi;
    logic [2:0][7:0] temp_lo;
    logic [2:0][7:0] overheat_lim;
    logic [7:0] overheat_hysteresis;
    logic [3:0][15:0] tach;
    logic [3:0][15:0] tach_min;
    logic [2:0] duty_on;
    logic [1:0] diode_fault;
    logic [7:0] overheat_time;
    logic [7:0] overheat_time_lim;
  } msf_meas_s;

  typedef struct packed {
    logic [6:0] st1;
    logic [7:0] st2;
    msf_cfg_s cfg;
    logic [31:0] rdata;
    logic err;
    logic rd_one;
    logic rd_two;
    logic [5:0] code_meta;
    logic [5:0] code_sync;
    logic [5:0] code_ref;
    logic ref_ok;
    logic [7:0] win_cnt;
  } msf_state_s;

  localparam msf_state_s STATE_RST = '0;

endpackage

/* File: src/msf_limit_cmp.sv */
`timescale 1ns/100ps
// window comparator: above high limit or at/below low limit
module msf_limit_cmp #(
  parameter int W = 8
) (
  // reading and limits
  input wire logic [W-1:0] value,
  input wire logic [W-1:0] hi,
  input wire logic [W-1:0] lo,
  // result
  output logic fault
);

  // strict above high, inclusive at low
  assign fault = (value > hi) || (value <= lo);

endmodule

/* File: src/msf_status.sv */
// The APB slave port was left to the implementer.
`timescale 1ns/100ps
module msf_status (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [msf_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  // measurement results and limits
  input wire msf_pkg::msf_meas_s meas,
  // cpu voltage code pins, bit 5 shared with the 12v input
  input wire logic [5:0] cpu_voltage_code,
  // multi-function pin 14 as gpio
  output logic gpio_out,
  output logic gpio_oe,
  // alert source
  output logic code_change_alert
);

  ////////////////////////////////////////////////////////////////////////////
  // state
  // every flop of the block lives in r; next_r is what the next edge
  // loads, so reset and clocking stay in a single process
  msf_pkg::msf_state_s r;
  msf_pkg::msf_state_s next_r;

  logic [4:0] volt_fault;
  logic [2:0] temp_fault;
  logic [6:0] cause_one;
  logic [7:0] cause_two;
  logic [7:0] hold_two;
  logic overheat_set;
  logic overheat_hold;
  logic code_change;
  logic win_tick;
  logic timer_over;
  logic fan_four_slow;
  logic [2:0] fan_slow;
  logic setup;
  logic access;
  logic [9:0] idx;
  logic rd_clear_one;
  logic rd_clear_two;
  logic wr_strobe;
  logic gpio_mode;

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  // overheat release floor, saturating at zero
  // a hysteresis above the limit would wrap to a high floor and free
  // the flag at once; clamping keeps it held instead
  function automatic logic [7:0] floor_of(input logic [7:0] lim,
                                          input logic [7:0] hyst);
    floor_of = (lim > hyst) ? 8'(lim - hyst) : 8'h00;
  endfunction

  // slow fan: count above the minimum-speed limit by one or more
  // the count is a period, so a slower fan gives a larger count
  function automatic logic is_slow(input logic [15:0] cnt,
                                   input logic [15:0] lim);
    is_slow = cnt > lim;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // limit comparators

  // limits are unsigned bytes; a reading equal to the low limit is a
  // fault, one equal to the high limit is not
  // voltage channels: 2.5v, core, supply, 5v, 12v
  for (genvar i = 0; i < 5; i++) begin : g_volt
    msf_limit_cmp #(.W(8)) u_cmp (
      .value(meas.volt[i]),
      .hi(meas.volt_hi[i]),
      .lo(meas.volt_lo[i]),
      .fault(volt_fault[i])
    );
  end

  // temperature channels: remote one, local, remote two
  // the same window test serves both limits of each channel
  for (genvar i = 0; i < 3; i++) begin : g_temp
    msf_limit_cmp #(.W(8)) u_cmp (
      .value(meas.temp[i]),
      .hi(meas.temp_hi[i]),
      .lo(meas.temp_lo[i]),
      .fault(temp_fault[i])
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  // overheat, fan and timer conditions
  // overheat sets strictly above the limit but holds down to the
  // release floor; between the two the flag neither sets nor clears
  always_comb begin
    overheat_set = 1'b0;
    overheat_hold = 1'b0;
    // any channel over its own limit raises the one overheat flag
    for (int i = 0; i < 3; i++) begin
      if (meas.temp[i] > meas.overheat_lim[i]) begin
        overheat_set = 1'b1;
      end
      // not yet below limit minus hysteresis
      if (meas.temp[i] >= floor_of(meas.overheat_lim[i],
                                   meas.overheat_hysteresis)) begin
        overheat_hold = 1'b1;
      end
    end
    for (int i = 0; i < 3; i++) begin
      // a fan at rest reads as stalled; only a driven fan can be slow
      // duty output off suppresses the flag
      fan_slow[i] = meas.duty_on[i] &&
                    is_slow(meas.tach[i], meas.tach_min[i]);
    end
    // fan four shares the third duty output
    fan_four_slow = meas.duty_on[2] &&
                    is_slow(meas.tach[3], meas.tach_min[3]);
    // measured assertion time against its programmed limit
    timer_over = meas.overheat_time > meas.overheat_time_lim;
  end

  ////////////////////////////////////////////////////////////////////////////
  // code change detection over the 11 us window
  // the window is sampled, not sliding: the synchronised code is
  // compared once per window with the copy taken a window earlier,
  // so a code that changes and returns inside one window goes unseen;
  // ref_ok masks the first tick, which has no reference yet
  assign win_tick = (r.win_cnt == msf_pkg::CODE_WIN_LAST);
  assign code_change = win_tick && r.ref_ok &&
                       (r.code_sync != r.code_ref);

  ////////////////////////////////////////////////////////////////////////////
  // fault causes per status bit
  // a cause is the live condition; it sets the latched flag on every
  // edge at which it is present and blocks a clear while it lasts
  always_comb begin
    cause_one = '0;
    cause_one[msf_pkg::ST1_V25] = volt_fault[0];
    cause_one[msf_pkg::ST1_VCORE] = volt_fault[1];
    cause_one[msf_pkg::ST1_VSUP] = volt_fault[2];
    // bit 3 serves either the 5v channel or the overheat timer
    cause_one[msf_pkg::ST1_V5_TIMER] = r.cfg.pin20_overheat ?
                                       timer_over :
                                       volt_fault[3];
    for (int i = 0; i < 3; i++) begin
      cause_one[msf_pkg::ST1_REMOTE_ONE + i] = temp_fault[i];
    end

    cause_two = '0;
    // bit 0 serves either the 12v channel or the code change detector
    cause_two[msf_pkg::ST2_V12_CODE] = r.cfg.pin21_code ?
                                       code_change :
                                       volt_fault[4];
    cause_two[msf_pkg::ST2_OVERHEAT] = overheat_set;
    // fans one to three on consecutive bits
    for (int i = 0; i < 3; i++) begin
      cause_two[msf_pkg::ST2_FAN_ONE + i] = fan_slow[i];
    end
    // bit 5 follows the role of pin 14; the reserved code never sets
    unique case (r.cfg.pin14_mode)
      msf_pkg::MSF_P14_TACH: begin
        cause_two[msf_pkg::ST2_FAN_FOUR] = fan_four_slow;
      end
      msf_pkg::MSF_P14_GPIO: begin
        cause_two[msf_pkg::ST2_FAN_FOUR] = 1'b0;
      end
      msf_pkg::MSF_P14_TIMER: begin
        cause_two[msf_pkg::ST2_FAN_FOUR] = timer_over;
      end
      default: begin
        cause_two[msf_pkg::ST2_FAN_FOUR] = 1'b0;
      end
    endcase
    // remote diode open or short, one bit per diode
    for (int i = 0; i < 2; i++) begin
      cause_two[msf_pkg::ST2_DIODE_ONE + i] =
        meas.diode_fault[i];
    end

    // what blocks a clear on read
    // overheat releases on a lower threshold than it sets on
    hold_two = cause_two;
    hold_two[msf_pkg::ST2_OVERHEAT] = overheat_hold;
  end

  ////////////////////////////////////////////////////////////////////////////
  // apb decode
  // no wait states: setup takes the read snapshot, and the access cycle
  // returns it and commits writes and clears at its closing edge
  assign setup = psel && !penable;
  assign access = psel && penable;
  assign idx = paddr[msf_pkg::ADDR_W-1:2];

  // read access that may clear the flags of its snapshot
  assign rd_clear_one = access && !pwrite && r.rd_one;
  assign rd_clear_two = access && !pwrite && r.rd_two;
  // only the low byte lane carries register bits
  assign wr_strobe = access && pwrite && pstrb[0];
  // pin 14 driven as a general-purpose output
  assign gpio_mode = (r.cfg.pin14_mode == msf_pkg::MSF_P14_GPIO);

  ////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    next_r = r;

    // two-stage sync of the code pins
    // the pins are asynchronous: only code_sync, the second flop,
    // feeds any logic
    next_r.code_meta = cpu_voltage_code;
    next_r.code_sync = r.code_meta;

    // window counter and reference sample
    // free-running; it wraps after the last cycle of the window
    if (win_tick) begin
      next_r.win_cnt = 8'h00;
      next_r.code_ref = r.code_sync;
      next_r.ref_ok = 1'b1;
    end else begin
      next_r.win_cnt = 8'(r.win_cnt + 8'h01);
    end

    // setup phase: snapshot read data and remember what was read
    // the snapshot fixes which flags this read may clear: a flag that
    // sets between setup and access is not in it and survives the read
    if (setup) begin
      next_r.rdata = msf_pkg::RDATA_RST;
      next_r.err = 1'b0;
      next_r.rd_one = 1'b0;
      next_r.rd_two = 1'b0;
      // status bits sit in the low byte; upper bits read as zero
      unique case (idx)
        msf_pkg::IDX_STATUS_ONE: begin
          next_r.rdata[7:0] = {|r.st2, r.st1};
          next_r.rd_one = !pwrite;
        end
        msf_pkg::IDX_STATUS_TWO: begin
          next_r.rdata[7:0] = r.st2;
          next_r.rd_two = !pwrite;
        end
        // pin roles: bit 0 pin 20, bit 1 pin 21, bits 3:2 pin 14
        msf_pkg::IDX_PIN_CFG: begin
          next_r.rdata[3:0] = r.cfg;
        end
        // live causes, for diagnosis; reading clears nothing
        msf_pkg::IDX_LIVE_CAUSE: begin
          next_r.rdata[15:0] = {cause_two, |cause_two, cause_one};
        end
        default: begin
          // unmapped: error response, read data stays zero
          next_r.err = 1'b1;
        end
      endcase
    end

    // clear on read: only bits shown in the snapshot whose cause is gone
    // a flag still caused at the clearing edge stays, so no fault that
    // persists is ever lost to a poll
    if (rd_clear_one) begin
      next_r.st1 = r.st1 & ~(r.rdata[6:0] & ~cause_one);
    end
    if (rd_clear_two) begin
      next_r.st2 = r.st2 & ~(r.rdata[7:0] & ~hold_two);
      // in gpio mode bit 5 is the pin level, not a flag: reads keep it
      if (gpio_mode) begin
        next_r.st2[msf_pkg::ST2_FAN_FOUR] =
          r.st2[msf_pkg::ST2_FAN_FOUR];
      end
    end

    // set wins over a clear in the same cycle
    // the set is applied after the clear, so an event on the clearing edge stays
    next_r.st1 = next_r.st1 | cause_one;
    next_r.st2 = next_r.st2 | cause_two;

    // writes: status one ignored, status two only bit 5 as gpio
    // the write comes after the set, and in gpio mode bit 5 has no
    // cause, so the written level is what the pin shows
    if (wr_strobe) begin
      if (idx == msf_pkg::IDX_STATUS_TWO && gpio_mode) begin
        next_r.st2[msf_pkg::ST2_FAN_FOUR] =
          pwdata[msf_pkg::ST2_FAN_FOUR];
      end
      // pin roles; the new role governs the causes from the next cycle
      if (idx == msf_pkg::IDX_PIN_CFG) begin
        next_r.cfg.pin20_overheat = pwdata[msf_pkg::CFG_PIN20];
        next_r.cfg.pin21_code = pwdata[msf_pkg::CFG_PIN21];
        next_r.cfg.pin14_mode = msf_pkg::msf_pin14_e'(
          pwdata[msf_pkg::CFG_PIN14_LO +: 2]);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register, cleared on reset
  // every flag, mode and the read snapshot start from zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= msf_pkg::STATE_RST;
    end else begin
      r <= next_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  // read data and error come from flops; every transfer is one access
  assign pready = 1'b1; // zero wait states
  assign prdata = r.rdata;
  assign pslverr = r.err && access;
  assign gpio_out = r.st2[msf_pkg::ST2_FAN_FOUR];
  // the pin is driven only while pin 14 serves as an output
  assign gpio_oe = gpio_mode;
  // latched change flag, usable by the alert logic
  // it follows the latched flag, so it stands until a read clears it
  assign code_change_alert = r.cfg.pin21_code &&
                             r.st2[msf_pkg::ST2_V12_CODE];

endmodule

/* File: verification/msf_status_props.sv */
`timescale 1ns/100ps
// pin level checks of the status flag block
module msf_status_props (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [msf_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  // readings and pins
  input wire msf_pkg::msf_meas_s meas,
  input wire logic gpio_out,
  input wire logic gpio_oe,
  input wire logic code_change_alert
);
  logic [9:0] idx;
  logic acc, setup, st1, st2, low0;
  logic [9:0] since_rst;

  // decode of the current transfer
  assign idx = paddr[11:2];
  assign acc = psel && penable;
  assign setup = psel && !penable;
  assign st1 = idx == msf_pkg::IDX_STATUS_ONE;
  assign st2 = idx == msf_pkg::IDX_STATUS_TWO;
  assign low0 = meas.volt[0] == meas.volt_lo[0];

  // cycles since reset release, saturating
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      since_rst <= 10'h000;
    end else if (since_rst != 10'h3ff) begin
      since_rst <= since_rst + 10'h001;
    end
  end

  default clocking dclk @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  a_reset_clean: assert property ($rose(presetn) |->
    prdata == 32'h0 && !gpio_oe && !code_change_alert)
    else $error("outputs not clear after reset");
  a_low_inclusive: assert property (
    $past(low0) && $past(presetn) && setup && st1 |=> prdata[0])
    else $error("low limit equality not flagged");
  a_diode_latched: assert property (
    $past(meas.diode_fault[0]) && $past(presetn) && setup && st2
    |=> prdata[6]) else $error("diode fault not latched");
  a_summary_bit: assert property (
    $past(meas.diode_fault[0]) && $past(presetn) && setup && st1
    |=> prdata[7]) else $error("summary bit missing");
  a_gpio_write: assert property (
    acc && pwrite && pstrb[0] && gpio_oe && st2
    |=> gpio_out == $past(pwdata[5])) else $error("gpio level wrong");
  a_code_quiet: assert property (since_rst < 10'h1ae |->
    !code_change_alert) else $error("code alert too early");
  a_alert_flag: assert property (
    code_change_alert && setup && st2 |=> prdata[0])
    else $error("alert without flag");
  a_status_word: assert property (acc && (st1 || st2) |->
    prdata[31:8] == 24'h0 && !pslverr) else $error("status word bad");
  a_unmapped_err: assert property (acc && idx > 10'h061 |->
    pslverr && prdata == 32'h0) else $error("unmapped not refused");

  c_refused: cover property (acc && pslverr);
  c_code_alert: cover property (code_change_alert);
  c_gpio_high: cover property (gpio_oe && gpio_out);
endmodule

bind msf_status msf_status_props u_msf_status_props (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
  .pslverr(pslverr), .meas(meas), .gpio_out(gpio_out),
  .gpio_oe(gpio_oe), .code_change_alert(code_change_alert));

/* File: verification/msf_apb_host.sv */
`timescale 1ns/100ps
// apb master standing in for the management host
module msf_apb_host (
  // clock
  input wire logic pclk,
  // request
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [11:0] paddr,
  output logic [31:0] pwdata,
  output logic [3:0] pstrb,
  // answer
  input wire logic pready,
  input wire logic [31:0] prdata,
  input wire logic pslverr
);
  // idle bus at time zero
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    pstrb = 4'hf;
  end

  // setup, access held until pready, then release
  task automatic xfer(input logic w, input logic [9:0] idx,
                      input logic [31:0] d, output logic [31:0] r,
                      output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    pwdata <= ~d; // released data does not linger
  endtask
endmodule

/* File: verification/msf_status_tb_top.sv */
`timescale 1ns/100ps
// self-checking bench for the status flag block
module msf_status_tb_top;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic gpio_out, gpio_oe, code_change_alert;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0] pstrb;
  logic [5:0] cpu_voltage_code;
  msf_pkg::msf_meas_s meas;
  int miscompares, checks_done;

  msf_status u_msf_status (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .meas(meas), .cpu_voltage_code(cpu_voltage_code),
    .gpio_out(gpio_out), .gpio_oe(gpio_oe),
    .code_change_alert(code_change_alert));
  msf_apb_host u_msf_apb_host (.pclk(pclk), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .pready(pready), .prdata(prdata), .pslverr(pslverr));

  // clock
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  // quiet readings, every one inside its window
  function automatic msf_pkg::msf_meas_s calm();
    msf_pkg::msf_meas_s m;
    m = '0;
    for (int i = 0; i < 5; i++) begin
      m.volt[i] = 8'h80;
      m.volt_hi[i] = 8'hc0;
      m.volt_lo[i] = 8'h40;
    end
    for (int i = 0; i < 3; i++) begin
      m.temp[i] = 8'h30;
      m.temp_hi[i] = 8'h60;
      m.temp_lo[i] = 8'h10;
      m.overheat_lim[i] = 8'h50;
    end
    for (int i = 0; i < 4; i++) begin
      m.tach[i] = 16'h0100;
      m.tach_min[i] = 16'h0200;
    end
    m.overheat_hysteresis = 8'h05;
    m.duty_on = 3'b111;
    m.overheat_time_lim = 8'h10;
    return m;
  endfunction

  // compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("FAIL %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // apply readings, then let one edge latch them
  task automatic put(input msf_pkg::msf_meas_s m);
    @(posedge pclk);
    meas <= m;
    @(posedge pclk);
  endtask

  task automatic rd(input logic [9:0] idx, input logic [31:0] exp);
    logic [31:0] r;
    logic e;
    u_msf_apb_host.xfer(1'b0, idx, 32'h0, r, e);
    chk(r, exp);
  endtask

  task automatic wr(input logic [9:0] idx, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    u_msf_apb_host.xfer(1'b1, idx, d, r, e);
  endtask

  // set, hold while present, clear only once the cause is gone
  task automatic latch(input msf_pkg::msf_meas_s m, input logic [9:0] idx,
                       input logic [31:0] exp);
    put(m);
    rd(idx, exp);
    rd(idx, exp);
    put(calm());
    rd(idx, exp);
    rd(idx, 32'h0);
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // reset values and an unmapped access
  task automatic t_reset();
    logic [31:0] r;
    logic e;
    rd(msf_pkg::IDX_STATUS_ONE, 32'h0);
    rd(msf_pkg::IDX_STATUS_TWO, 32'h0);
    u_msf_apb_host.xfer(1'b0, 10'h3ff, 32'h0, r, e);
    chk({r[30:0], e}, 32'h1);
    $display("done reset");
  endtask

  // voltage and temperature windows of status one
  task automatic t_limits();
    msf_pkg::msf_meas_s m;
    for (int i = 0; i < 4; i++) begin
      m = calm();
      m.volt[i] = m.volt_hi[i];
      put(m);
      rd(msf_pkg::IDX_STATUS_ONE, 32'h0);
      m.volt[i] = i[0] ? m.volt_hi[i] + 8'h01 : m.volt_lo[i];
      latch(m, msf_pkg::IDX_STATUS_ONE, 32'h1 << i);
    end
    for (int i = 0; i < 3; i++) begin
      m = calm();
      m.temp[i] = m.temp_lo[i];
      latch(m, msf_pkg::IDX_STATUS_ONE, 32'h10 << i);
    end
    $display("done limits");
  endtask

  // status two sources and the summary bit
  task automatic t_second();
    msf_pkg::msf_meas_s m;
    m = calm();
    m.volt[4] = 8'hc1;
    latch(m, msf_pkg::IDX_STATUS_TWO, 32'h1);
    for (int i = 0; i < 2; i++) begin
      m = calm();
      m.diode_fault[i] = 1'b1;
      latch(m, msf_pkg::IDX_STATUS_TWO, 32'h40 << i);
    end
    for (int i = 0; i < 4; i++) begin
      m = calm();
      m.tach[i] = m.tach_min[i];
      put(m);
      rd(msf_pkg::IDX_STATUS_TWO, 32'h0);
      m.tach[i] = m.tach_min[i] + 16'h0001;
      m.duty_on[i > 2 ? 2 : i] = 1'b0;
      put(m);
      rd(msf_pkg::IDX_STATUS_TWO, 32'h0);
      m.duty_on = 3'b111;
      latch(m, msf_pkg::IDX_STATUS_TWO, 32'h4 << i);
    end
    m = calm();
    m.diode_fault[0] = 1'b1;
    put(m);
    rd(msf_pkg::IDX_STATUS_ONE, 32'h80);
    rd(msf_pkg::IDX_LIVE_CAUSE, 32'h4080);
    put(calm());
    rd(msf_pkg::IDX_STATUS_TWO, 32'h40);
    rd(msf_pkg::IDX_STATUS_ONE, 32'h0);
    $display("done second");
  endtask

  // overheat flag and its hysteresis on clearing
  task automatic t_overheat();
    msf_pkg::msf_meas_s m;
    m = calm();
    m.temp[2] = 8'h51;
    put(m);
    rd(msf_pkg::IDX_STATUS_TWO, 32'h2);
    m.temp[2] = 8'h4b;
    put(m);
    rd(msf_pkg::IDX_STATUS_TWO, 32'h2);
    rd(msf_pkg::IDX_STATUS_TWO, 32'h2);
    m.temp[2] = 8'h4a;
    put(m);
    rd(msf_pkg::IDX_STATUS_TWO, 32'h2);
    rd(msf_pkg::IDX_STATUS_TWO, 32'h0);
    $display("done overheat");
  endtask

  // timer modes, then pin 14 as gpio and ignored writes
  task automatic t_pins();
    msf_pkg::msf_meas_s m;
    wr(msf_pkg::IDX_PIN_CFG, 32'h9);
    m = calm();
    m.overheat_time = 8'h11;
    put(m);
    rd(msf_pkg::IDX_STATUS_ONE, 32'h88);
    rd(msf_pkg::IDX_STATUS_TWO, 32'h20);
    put(calm());
    rd(msf_pkg::IDX_STATUS_TWO, 32'h20);
    rd(msf_pkg::IDX_STATUS_ONE, 32'h8);
    wr(msf_pkg::IDX_PIN_CFG, 32'h4);
    rd(msf_pkg::IDX_PIN_CFG, 32'h4);
    wr(msf_pkg::IDX_STATUS_TWO, 32'hff);
    @(negedge pclk);
    chk({30'h0, gpio_oe, gpio_out}, 32'h3);
    rd(msf_pkg::IDX_STATUS_TWO, 32'h20);
    wr(msf_pkg::IDX_STATUS_ONE, 32'hff);
    rd(msf_pkg::IDX_STATUS_ONE, 32'h80);
    wr(msf_pkg::IDX_STATUS_TWO, 32'h0);
    rd(msf_pkg::IDX_STATUS_TWO, 32'h0);
    chk({31'h0, gpio_out}, 32'h0);
    wr(msf_pkg::IDX_PIN_CFG, 32'h0);
    $display("done pins");
  endtask

  // cpu voltage code change raises flag and alert
  task automatic t_code();
    int n;
    wr(msf_pkg::IDX_PIN_CFG, 32'h2);
    cpu_voltage_code <= 6'h15;
    n = 0;
    while (code_change_alert !== 1'b1 && n < 700) begin
      @(posedge pclk);
      n++;
    end
    chk({31'h0, code_change_alert}, 32'h1);
    rd(msf_pkg::IDX_STATUS_TWO, 32'h1);
    $display("done code");
  endtask

  // main sequence
  initial begin
    presetn = 1'b0;
    cpu_voltage_code = 6'h00;
    meas = calm();
    miscompares = 0;
    checks_done = 0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_limits();
    t_second();
    t_overheat();
    t_pins();
    t_code();
    give_verdict();
  end

  // watchdog, 20000 cycles
  initial begin
    #1000000;
    miscompares++;
    give_verdict();
  end
endmodule
